//--- lxc_pkg.sv
// package for the lin transceiver mode and fault controller
`default_nettype none
package lxc_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int CS_FILT_US = 10;
    localparam int SHORT_EVAL_US = 25;
    localparam int TXD_TO_MS = 25;
    localparam int BUS_TO_MS = 25;
    localparam int WAKE_DEB_US = 20;
    // least times round down to whole cycles
    localparam int CS_FILT_CYC = (CLK_HZ / 1_000_000) * CS_FILT_US;
    localparam int SHORT_EVAL_CYC = (CLK_HZ / 1_000_000) * SHORT_EVAL_US;
    localparam int TXD_TO_CYC = (CLK_HZ / 1_000) * TXD_TO_MS;
    localparam int BUS_TO_CYC = (CLK_HZ / 1_000) * BUS_TO_MS;
    localparam int WAKE_DEB_CYC = (CLK_HZ / 1_000_000) * WAKE_DEB_US;
    localparam int CNT_W = 20;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        LXC_POR,
        LXC_READY,
        LXC_OPER,
        LXC_TXOFF,
        LXC_PDOWN
    } lxc_mode_t;

    // pins facing the bus
    typedef struct packed {
        logic bus_drive_low;
        logic pullup_on;
    } lxc_bus_t;
endpackage : lxc_pkg
`default_nettype wire

//--- lxc_fifo.sv
// small valid/ready fifo on the transmit data path
`default_nettype none
module lxc_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic full;
    logic empty;

    assign empty = (wp_q == rp_q);
    assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out = mem_q[rp_q[AW-1:0]];

    // pointers carry a wrap bit so full and empty stay honest
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (wr_valid_in && !full) begin
                wp_q <= wp_q + 1'b1;
            end
            if (rd_ready_in && !empty) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (wr_valid_in && !full) begin
            mem_q[wp_q[AW-1:0]] <= wr_data_in;
        end
    end
endmodule : lxc_fifo
`default_nettype wire

//--- lxc_ctrl.sv
// lin transceiver mode sequencer, time-outs and fault pin control
`default_nettype none
module lxc_ctrl #(
    parameter int CS_FILT_CYC = lxc_pkg::CS_FILT_CYC,
    parameter int SHORT_EVAL_CYC = lxc_pkg::SHORT_EVAL_CYC,
    parameter int TXD_TO_CYC = lxc_pkg::TXD_TO_CYC,
    parameter int BUS_TO_CYC = lxc_pkg::BUS_TO_CYC,
    parameter int WAKE_DEB_CYC = lxc_pkg::WAKE_DEB_CYC,
    parameter bit REVISED_WAKE = 1'b1,
    parameter int FIFO_DEPTH = lxc_pkg::FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic supply_ok_in,
    input wire logic cs_in,
    input wire logic wake_n_in,
    input wire logic txd_in,
    input wire logic bus_line_in,
    input wire logic rxd_pin_in,
    input wire logic fault_tx_enable_pin_in,
    input wire logic thermal_sd_in,
    output logic rxd_out,
    output logic rxd_oe_n_out,
    output logic fault_tx_enable_pin_out,
    output logic fault_tx_enable_pin_oe_n_out,
    output logic bus_drive_low_out,
    output logic bus_pullup_on_out,
    output logic regulator_enable_out,
    output logic tx_active_out,
    output logic txd_ready_out
);
    typedef struct packed {
        lxc_pkg::lxc_mode_t mode;
        logic cs_f;
        logic [lxc_pkg::CNT_W-1:0] cs_cnt;
        logic [lxc_pkg::CNT_W-1:0] short_cnt;
        logic [lxc_pkg::CNT_W-1:0] txd_cnt;
        logic [lxc_pkg::CNT_W-1:0] bus_cnt;
        logic [lxc_pkg::CNT_W-1:0] wake_cnt;
        logic wake_low_ok;
        logic txd_to;
        logic bus_to;
        logic mon_flt;
        logic short_flt;
        logic txd_prev;
        logic wake_prev;
        logic bus_prev;
        logic rxd;
        logic flt_low;
        lxc_pkg::lxc_bus_t bus;
        logic vreg;
        logic tx_act;
    } lxc_state_t;

    lxc_state_t s_q;
    lxc_state_t s_d;
    logic fifo_txd;
    logic fifo_valid;
    logic fifo_rd;
    logic txd_eff;
    logic tx_en;
    logic host_off;

    // tx samples are buffered; drained every cycle outside power-down, ready only flags full and samples arriving then are dropped
    lxc_fifo #(
        .WIDTH(1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_data_in(txd_in),
        .wr_valid_in(1'b1),
        .wr_ready_out(txd_ready_out),
        .rd_data_out(fifo_txd),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(fifo_rd)
    );
    // drain stalls while power-down: bus is not driven then
    assign fifo_rd = (s_q.mode != lxc_pkg::LXC_PDOWN);
    // empty fifo reads as the idle high level of the pull-up
    assign txd_eff = fifo_valid ? fifo_txd : 1'b1;

    // host drive low is told apart from our own drive
    assign host_off = !fault_tx_enable_pin_in && !s_q.flt_low;

    always_comb begin
        s_d = s_q;
        s_d.txd_prev = txd_eff;
        s_d.wake_prev = wake_n_in;
        s_d.bus_prev = bus_line_in;
        // chip-select filter: level must hold for the whole window
        if (cs_in == s_q.cs_f) begin
            s_d.cs_cnt = '0;
        end else if (s_q.cs_cnt >= lxc_pkg::CNT_W'(CS_FILT_CYC - 1)) begin
            s_d.cs_f = cs_in;
            s_d.cs_cnt = '0;
        end else begin
            s_d.cs_cnt = s_q.cs_cnt + 1'b1;
        end
        // tx dominant timer, clears on rising edge
        if (txd_eff) begin
            s_d.txd_cnt = '0;
            s_d.short_cnt = '0;
            s_d.short_flt = 1'b0;
            if (!s_q.txd_prev) begin
                s_d.txd_to = 1'b0;
            end
        end else begin
            if (s_q.txd_cnt >= lxc_pkg::CNT_W'(TXD_TO_CYC - 1)) begin
                s_d.txd_to = 1'b1;
            end else begin
                s_d.txd_cnt = s_q.txd_cnt + 1'b1;
            end
            if (s_q.short_cnt >= lxc_pkg::CNT_W'(SHORT_EVAL_CYC - 1)) begin
                s_d.short_flt = bus_line_in && s_q.tx_act;
            end else begin
                s_d.short_cnt = s_q.short_cnt + 1'b1;
            end
        end
        // bus dominant timer, any recessive clears the count; the time-out flag clears only with cs_f high
        if (bus_line_in) begin
            s_d.bus_cnt = '0;
            if (s_q.cs_f) begin
                s_d.bus_to = 1'b0;
            end
        end else if (s_q.bus_cnt >= lxc_pkg::CNT_W'(BUS_TO_CYC - 1)) begin
            s_d.bus_to = 1'b1;
        end else begin
            s_d.bus_cnt = s_q.bus_cnt + 1'b1;
        end
        // rx monitor, outside power-down and por: our rx must be high whenever bus is recessive
        if (s_q.mode != lxc_pkg::LXC_PDOWN && s_q.mode != lxc_pkg::LXC_POR) begin
            // compare against what we released last cycle, so a bus edge is no fault
            if (s_q.rxd && bus_line_in && !rxd_pin_in) begin
                s_d.mon_flt = 1'b1;
            end
        end
        if (!bus_line_in || rxd_pin_in) begin
            s_d.mon_flt = s_d.mon_flt && !(bus_line_in && rxd_pin_in);
        end
        // wake detect on bus during power-down
        if (s_q.mode == lxc_pkg::LXC_PDOWN && !bus_line_in) begin
            if (s_q.wake_cnt >= lxc_pkg::CNT_W'(WAKE_DEB_CYC - 1)) begin
                s_d.wake_low_ok = 1'b1;
            end else begin
                s_d.wake_cnt = s_q.wake_cnt + 1'b1;
            end
        end else if (bus_line_in) begin
            s_d.wake_cnt = '0;
        end
        // mode sequencing
        unique case (s_q.mode)
            lxc_pkg::LXC_POR: begin
                if (supply_ok_in) begin
                    s_d.mode = cs_in ? lxc_pkg::LXC_TXOFF : lxc_pkg::LXC_READY;
                    s_d.cs_f = cs_in;
                end
            end
            lxc_pkg::LXC_READY: begin
                if (s_q.cs_f) begin
                    s_d.mode = lxc_pkg::LXC_TXOFF;
                end
            end
            lxc_pkg::LXC_OPER, lxc_pkg::LXC_TXOFF: begin
                if (!s_q.cs_f) begin
                    s_d.mode = lxc_pkg::LXC_PDOWN;
                end else if (s_q.mon_flt || s_q.txd_to || s_q.bus_to
                        || !fault_tx_enable_pin_in || thermal_sd_in) begin
                    s_d.mode = lxc_pkg::LXC_TXOFF;
                end else if (txd_eff) begin
                    s_d.mode = lxc_pkg::LXC_OPER;
                end
            end
            lxc_pkg::LXC_PDOWN: begin
                s_d.wake_low_ok = s_d.wake_low_ok;
                if (s_q.cs_f
                        || (s_q.wake_prev && !wake_n_in)
                        || (!REVISED_WAKE && s_q.wake_low_ok)
                        || (REVISED_WAKE && s_q.wake_low_ok && bus_line_in
                            && !s_q.bus_prev)) begin
                    s_d.mode = lxc_pkg::LXC_READY;
                    s_d.wake_low_ok = 1'b0;
                    s_d.wake_cnt = '0;
                end
            end
        endcase
        // outputs, taken from the next state so they stand with the mode
        s_d.tx_act = (s_d.mode == lxc_pkg::LXC_OPER) && s_d.cs_f
            && fault_tx_enable_pin_in;
        s_d.bus.bus_drive_low = s_d.tx_act && !txd_eff;
        s_d.bus.pullup_on = s_d.tx_act;
        s_d.rxd = (s_d.mode == lxc_pkg::LXC_PDOWN) ? 1'b1 : bus_line_in;
        s_d.flt_low = (s_d.mode != lxc_pkg::LXC_PDOWN && s_d.mode != lxc_pkg::LXC_POR)
            && (s_d.mon_flt || s_d.bus_to || s_d.short_flt || thermal_sd_in);
        s_d.vreg = (s_d.mode != lxc_pkg::LXC_PDOWN) && (s_d.mode != lxc_pkg::LXC_POR);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '{mode: lxc_pkg::LXC_POR, txd_prev: 1'b1, wake_prev: 1'b1,
                bus_prev: 1'b1, rxd: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign rxd_out = 1'b0;
    assign rxd_oe_n_out = s_q.rxd;
    assign fault_tx_enable_pin_out = 1'b0;
    assign fault_tx_enable_pin_oe_n_out = !s_q.flt_low;
    assign bus_drive_low_out = s_q.bus.bus_drive_low;
    assign bus_pullup_on_out = s_q.bus.pullup_on;
    assign regulator_enable_out = s_q.vreg;
    assign tx_active_out = s_q.tx_act;

    property no_drive_off_p;
        @(posedge clk_in) disable iff (rst_in) !s_q.tx_act |-> !bus_drive_low_out;
    endproperty
    drive_gate_a: assert property (no_drive_off_p) else $error("bus driven while off");
    vreg_mode_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_q.mode == lxc_pkg::LXC_PDOWN) |-> !regulator_enable_out)
        else $error("regulator on in power-down");
    cs_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !s_q.cs_f |-> !tx_active_out) else $error("tx active with cs low");
    fault_pin_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_q.bus_to && s_q.mode == lxc_pkg::LXC_TXOFF) |-> !fault_tx_enable_pin_oe_n_out)
        else $error("fault pin not low");
    pullup_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !tx_active_out |-> !bus_pullup_on_out) else $error("pullup on while off");
    thermal_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (thermal_sd_in && s_q.cs_f && s_q.mode == lxc_pkg::LXC_OPER)
        |=> !fault_tx_enable_pin_oe_n_out)
        else $error("thermal not reported");
    rx_mirror_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_q.mode == lxc_pkg::LXC_OPER) |-> (rxd_oe_n_out == $past(bus_line_in)))
        else $error("rx not mirroring");
    host_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (host_off && s_q.mode == lxc_pkg::LXC_OPER) |=> !tx_active_out)
        else $error("host off ignored");

    // wake pin falling edge as seen by the sequencer
    sequence wake_fall_s;
        s_q.wake_prev && !wake_n_in;
    endsequence
    // power-down with the wake pin edge present
    sequence pdown_wake_s;
        (s_q.mode == lxc_pkg::LXC_PDOWN) ##0 wake_fall_s;
    endsequence
    wake_pin_a: assert property (@(posedge clk_in) disable iff (rst_in)
        pdown_wake_s |=> (s_q.mode == lxc_pkg::LXC_READY))
        else $error("wake pin ignored");
    // monitor fault takes the transmitter off while selected
    mon_txoff_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_q.mon_flt && s_q.cs_f && s_q.mode == lxc_pkg::LXC_OPER)
        |=> (s_q.mode == lxc_pkg::LXC_TXOFF))
        else $error("monitor fault ignored");
    ready_tx_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_q.mode == lxc_pkg::LXC_READY) |-> !tx_active_out)
        else $error("tx active in ready");
    txd_timeout_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_q.txd_to && s_q.cs_f && s_q.mode == lxc_pkg::LXC_OPER)
        |=> (s_q.mode == lxc_pkg::LXC_TXOFF))
        else $error("tx timeout ignored");
    bus_timeout_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_q.bus_to && s_q.cs_f && s_q.mode == lxc_pkg::LXC_OPER)
        |=> (s_q.mode == lxc_pkg::LXC_TXOFF))
        else $error("bus timeout ignored");
    // sampled pin low must gate the driver on the very next edge
    pin_low_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !fault_tx_enable_pin_in |=> !tx_active_out)
        else $error("tx active with pin low");
    pdown_rx_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_q.mode == lxc_pkg::LXC_PDOWN) |-> rxd_oe_n_out)
        else $error("rx driven in power-down");
    short_fault_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_q.short_flt && (s_q.mode == lxc_pkg::LXC_OPER || s_q.mode == lxc_pkg::LXC_TXOFF))
        |-> !fault_tx_enable_pin_oe_n_out)
        else $error("short not reported");
    vreg_on_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_q.mode == lxc_pkg::LXC_READY || s_q.mode == lxc_pkg::LXC_OPER
            || s_q.mode == lxc_pkg::LXC_TXOFF) |-> regulator_enable_out)
        else $error("regulator off while awake");
    cs_pdown_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (!s_q.cs_f && s_q.mode == lxc_pkg::LXC_OPER) |=> (s_q.mode == lxc_pkg::LXC_PDOWN))
        else $error("no power-down on cs low");
endmodule : lxc_ctrl
`default_nettype wire

//--- lxc_bus_model.sv
// far side model: bus nodes, rxd pull-up and host on the fault pin
`default_nettype none
module lxc_bus_model (
    input wire logic drive_low_in,
    input wire logic node_low_in,
    input wire logic short_bat_in,
    input wire logic rxd_in,
    input wire logic rxd_oe_n_in,
    input wire logic rxd_stuck_in,
    input wire logic flt_in,
    input wire logic flt_oe_n_in,
    input wire logic host_low_in,
    output logic bus_out,
    output logic rxd_pin_out,
    output logic flt_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // wired-and bus with master pull-up; a battery short overrides all drivers
    assign bus_out = short_bat_in | !(drive_low_in | node_low_in);
    // open-drain rxd with pull-up; stuck-low models a shorted receive line
    assign rxd_pin_out = !rxd_stuck_in & (rxd_oe_n_in | rxd_in);
    // host may pull the fault pin low as a transmitter off command
    assign flt_pin_out = !host_low_in & (flt_oe_n_in | flt_in);
endmodule : lxc_bus_model
`default_nettype wire

//--- tb_lxc_ctrl.sv
// self-checking bench for the lin transceiver controller and its fifo
`default_nettype none
module tb_lxc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'h0, rst_in = 1'h1, cs = 1'h0, wk = 1'h1, txd = 1'h1, ts = 1'h0;
    logic node = 1'h0, sbat = 1'h0, stuck = 1'h0, hlow = 1'h0, sup = 1'h0;
    logic bus, rxp, fpin, rxo, rxoe, fo, foe, drv, pull, ren, act, rdy;
    logic seen_flt = 1'h0, seen_drv = 1'h0, seen_off = 1'h0;
    int n_mismatch = 0, comparisons = 0, cyc = 0;

    // short counts keep the run brief; expectations use the same figures
    lxc_ctrl #(.CS_FILT_CYC(8), .SHORT_EVAL_CYC(20), .TXD_TO_CYC(200), .BUS_TO_CYC(200),
        .WAKE_DEB_CYC(16)) lxc_ctrl_i (
        .clk_in(clk_in), .rst_in(rst_in), .supply_ok_in(sup), .cs_in(cs),
        .wake_n_in(wk), .txd_in(txd), .bus_line_in(bus), .rxd_pin_in(rxp),
        .fault_tx_enable_pin_in(fpin), .thermal_sd_in(ts), .rxd_out(rxo),
        .rxd_oe_n_out(rxoe), .fault_tx_enable_pin_out(fo),
        .fault_tx_enable_pin_oe_n_out(foe), .bus_drive_low_out(drv),
        .bus_pullup_on_out(pull), .regulator_enable_out(ren), .tx_active_out(act),
        .txd_ready_out(rdy));
    lxc_bus_model lxc_bus_model_i (
        .drive_low_in(drv), .node_low_in(node), .short_bat_in(sbat), .rxd_in(rxo),
        .rxd_oe_n_in(rxoe), .rxd_stuck_in(stuck), .flt_in(fo), .flt_oe_n_in(foe),
        .host_low_in(hlow), .bus_out(bus), .rxd_pin_out(rxp), .flt_pin_out(fpin));

    always #12.5 clk_in = ~clk_in;

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick
    // outputs are read mid-cycle, well clear of the launching edge
    task automatic see(input int n);
        tick(n);
        @(negedge clk_in);
    endtask : see
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    // sticky records catch short pulses between checks; also the hang limit
    always @(posedge clk_in) begin
        if (fpin === 1'h0) seen_flt <= 1'h1;
        if (foe === 1'h0) seen_drv <= 1'h1;
        if (ren === 1'h0) seen_off <= 1'h1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up;
        end
    end

    // main sequence
    initial begin
        tick(12);
        rst_in <= 1'h0;
        txd <= 1'h0;
        see(5);
        chk("regulator_por", ren, 0);
        tick(1);
        sup <= 1'h1;
        see(40);
        chk("regulator", ren, 1);
        chk("tx_active", act, 0);
        chk("bus_drive", drv, 0);
        chk("pullup", pull, 0);
        chk("rxd", rxp, 1);
        tick(1);
        node <= 1'h1;
        see(4);
        chk("rxd", rxp, 0);
        tick(1);
        node <= 1'h0;
        txd <= 1'h1;
        cs <= 1'h1;
        see(40);
        chk("tx_active", act, 1);
        chk("pullup", pull, 1);
        seen_off = 1'h0;
        tick(1);
        cs <= 1'h0;
        tick(3);
        cs <= 1'h1;
        see(30);
        chk("glitch", seen_off, 0);
        chk("tx_active", act, 1);
        tick(1);
        txd <= 1'h0;
        see(5);
        chk("bus_drive", drv, 1);
        chk("rxd", rxp, 0);
        see(230);
        chk("bus_drive", drv, 0);
        chk("tx_active", act, 0);
        tick(1);
        txd <= 1'h1;
        see(30);
        chk("tx_active", act, 1);
        seen_flt = 1'h0;
        tick(1);
        node <= 1'h1;
        see(230);
        chk("tx_active", act, 0);
        chk("fault", seen_flt, 1);
        tick(1);
        node <= 1'h0;
        see(30);
        chk("tx_active", act, 1);
        seen_drv = 1'h0;
        tick(1);
        hlow <= 1'h1;
        see(20);
        chk("tx_active", act, 0);
        chk("pullup", pull, 0);
        chk("fault_drive", seen_drv, 0);
        tick(1);
        hlow <= 1'h0;
        see(30);
        chk("tx_active", act, 1);
        seen_flt = 1'h0;
        tick(1);
        sbat <= 1'h1;
        txd <= 1'h0;
        see(10);
        chk("early_fault", seen_flt, 0);
        see(30);
        chk("fault", seen_flt, 1);
        tick(1);
        sbat <= 1'h0;
        txd <= 1'h1;
        see(30);
        chk("tx_active", act, 1);
        seen_flt = 1'h0;
        tick(1);
        stuck <= 1'h1;
        see(20);
        chk("tx_active", act, 0);
        chk("fault", seen_flt, 1);
        seen_flt = 1'h0;
        tick(1);
        stuck <= 1'h0;
        ts <= 1'h1;
        see(10);
        chk("fault", seen_flt, 1);
        tick(1);
        ts <= 1'h0;
        cs <= 1'h0;
        see(30);
        chk("regulator", ren, 0);
        tick(1);
        node <= 1'h1;
        see(30);
        chk("rxd", rxp, 1);
        chk("regulator", ren, 0);
        tick(1);
        node <= 1'h0;
        see(30);
        chk("regulator", ren, 1);
        chk("tx_active", act, 0);
        tick(1);
        cs <= 1'h1;
        tick(40);
        cs <= 1'h0;
        see(30);
        chk("regulator", ren, 0);
        chk("txd_ready", rdy, 0);
        tick(1);
        wk <= 1'h0;
        see(20);
        chk("regulator", ren, 1);
        // tx buffer drains stale samples after wake, then tx reaches the bus again
        chk("txd_ready", rdy, 1);
        tick(1);
        wk <= 1'h1;
        cs <= 1'h1;
        see(40);
        chk("tx_active", act, 1);
        tick(1);
        txd <= 1'h0;
        see(20);
        chk("bus_drive", drv, 1);
        tick(1);
        txd <= 1'h1;
        see(20);
        chk("bus_drive", drv, 0);
        wrap_up;
    end
endmodule : tb_lxc_ctrl
`default_nettype wire
